// [matrix_address_decode_boot_remap.sv]
`default_nettype none
module matrix_address_decode_boot_remap
	import matrix_decode_pkg::*;
#(
	parameter int MASTERS = matrix_decode_pkg::NUM_MASTERS
)
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic BOOT_SOURCE_SELECT_PIN,
	input wire logic REMAP_SET,
	input wire logic REMAP_CLEAR,
	input wire logic CS1_SDRAM_ASSIGN,
	input wire logic [MASTERS*matrix_decode_pkg::ADDR_W-1:0] HADDR,
	input wire logic [MASTERS-1:0] HSEL_VALID,
	output logic [MASTERS*4-1:0] SLAVE_SEL,
	output logic [MASTERS-1:0] DECODE_ABORT,
	output logic [MASTERS*3-1:0] EXT_CS_INDEX,
	output logic [MASTERS-1:0] CS_TO_SDRAM,
	output logic REMAP_STATE,
	output logic BOOT_FROM_ROM,
	output logic SMC_BYTE_SELECT_MODE,
	output logic [1:0] SMC_BUS_WIDTH,
	output logic SMC_RW_CS_CONTROLLED
);
	import matrix_decode_pkg::*;

	// ------------------------------------------------------------
	// Sizes
	// ------------------------------------------------------------
	// The processor instruction and data ports are the lowest masters
	localparam int CPU_MASTERS = 2;
	localparam int SEL_W = $bits(slave_t);
	localparam int CS_W = 3;
	// Two synchroniser stages, then one capture edge
	localparam int SYNC_DEPTH = 2;
	localparam logic [1:0] CAPTURE_EDGE = 2'(SYNC_DEPTH + 1);

	// ------------------------------------------------------------
	// Boot pin capture and remap
	// ------------------------------------------------------------
	logic pin_meta_q;
	logic pin_sync_q;
	logic boot_rom_q;
	logic boot_taken_q;
	logic remap_q;
	logic remap_d;
	logic [SYNC_DEPTH-1:0] warm_q;
	logic [SYNC_DEPTH-1:0] warm_d;
	logic [1:0] since_rel_q;
	wire sync_ready = warm_q[SYNC_DEPTH-1];

	// Fill marker, so capture waits until both stages hold the pin
	assign warm_d = {warm_q[SYNC_DEPTH-2:0], 1'b1};

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			pin_meta_q <= 1'b0;
			pin_sync_q <= 1'b0;
			warm_q <= '0;
		end
		else
		begin
			pin_meta_q <= BOOT_SOURCE_SELECT_PIN;
			pin_sync_q <= pin_meta_q;
			warm_q <= warm_d;
		end
	end

	// Latched once after release; the pin may change freely afterwards.
	// Decoding uses ROM until capture is done, three edges in.
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			boot_rom_q <= 1'b1;
			boot_taken_q <= 1'b0;
		end
		else if (!boot_taken_q && sync_ready)
		begin
			boot_rom_q <= pin_sync_q;
			boot_taken_q <= 1'b1;
		end
	end

	// Remap is software's to raise and to clear; set wins over clear, and reset also clears it.
	assign remap_d = REMAP_SET ? 1'b1 : (REMAP_CLEAR ? 1'b0 : remap_q);

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			remap_q <= 1'b0;
		else
			remap_q <= remap_d;
	end

	assign REMAP_STATE = remap_q;
	assign BOOT_FROM_ROM = boot_rom_q;

	// The static controller is tied to its safe mode for every boot source, not only external boot
	wire ext_boot = !boot_rom_q && !remap_q;
	assign SMC_BYTE_SELECT_MODE = SMC_BYTE_SELECT;
	assign SMC_BUS_WIDTH = SMC_WIDTH_16;
	assign SMC_RW_CS_CONTROLLED = SMC_RW_BY_CS;

	// ------------------------------------------------------------
	// Address decode, shared by all masters
	// ------------------------------------------------------------
	function automatic slave_t decode_slave(input logic [ADDR_W-1:0] addr, input logic cpu,
		input logic remap, input logic boot_rom);
		logic [BANK_W-1:0] bank;
		logic [AREA_W-1:0] area;
		bank = addr[BANK_LSB +: BANK_W];
		area = addr[AREA_LSB +: AREA_W];
		decode_slave = SLV_NONE;
		if (bank == BANK_INTERNAL)
		begin
			if (area == AREA_BOOT)
			begin
				if (remap)
					decode_slave = SLV_RAM0;
				else if (boot_rom)
					decode_slave = SLV_ROM;
				else
					decode_slave = SLV_EXT;
			end
			else if (area == AREA_ROM)
				decode_slave = SLV_ROM;
			else if (area == AREA_RAM0)
				decode_slave = SLV_RAM0;
			else if (area == AREA_RAM1)
				decode_slave = SLV_RAM1;
			else if (area == AREA_USBH && cpu)
				decode_slave = SLV_USBH;
		end
		else if (bank >= BANK_EXT_FIRST && bank <= BANK_EXT_LAST)
			decode_slave = SLV_EXT;
		else if (bank == BANK_PERIPH)
			decode_slave = SLV_PERIPH;
	endfunction

	// Boot area and bank zero both reach chip select zero; other banks index by their low three bits.
	function automatic logic [2:0] cs_of(input logic [ADDR_W-1:0] addr);
		logic [BANK_W-1:0] bank;
		bank = addr[BANK_LSB +: BANK_W];
		cs_of = (bank == BANK_INTERNAL) ? CS_ZERO : 3'(bank);
	endfunction

	genvar m;
	generate
		for (m = 0; m < MASTERS; m++)
		begin : g_master
			// Only the two processor ports may reach the USB host area
			localparam logic IS_CPU = (m < CPU_MASTERS);
			wire [ADDR_W-1:0] addr = HADDR[m*ADDR_W +: ADDR_W];
			wire [BANK_W-1:0] bank = addr[BANK_LSB +: BANK_W];
			wire [AREA_W-1:0] area = addr[AREA_LSB +: AREA_W];
			wire in_ext = (bank >= BANK_EXT_FIRST) && (bank <= BANK_EXT_LAST);
			wire at_boot = (bank == BANK_INTERNAL) && (area == AREA_BOOT);
			slave_t sel;
			assign sel = decode_slave(addr, IS_CPU, remap_q, boot_rom_q);
			wire [2:0] cs = cs_of(addr);
			assign SLAVE_SEL[m*4 +: 4] = HSEL_VALID[m] ? sel : SLV_NONE;
			assign DECODE_ABORT[m] = HSEL_VALID[m] && (sel == SLV_NONE);
			assign EXT_CS_INDEX[m*3 +: 3] = cs;
			// Chip select zero never goes to SDRAM
			assign CS_TO_SDRAM[m] = (sel == SLV_EXT) && (cs == CS_ONE) && CS1_SDRAM_ASSIGN;

			chk_abort_unused: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && addr[BANK_LSB +: BANK_W] > BANK_EXT_LAST
				&& addr[BANK_LSB +: BANK_W] != BANK_PERIPH |-> DECODE_ABORT[m])
				else $error("unused bank not aborted");
			chk_ext_bank: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && addr[BANK_LSB +: BANK_W] == 4'h3
				|-> SLAVE_SEL[m*4 +: 4] == SLV_EXT && EXT_CS_INDEX[m*3 +: 3] == 3'h3)
				else $error("bank three not on chip select three");
			chk_periph_bank: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && addr[BANK_LSB +: BANK_W] == BANK_PERIPH |-> SLAVE_SEL[m*4 +: 4] == SLV_PERIPH)
				else $error("bank fifteen not peripheral");
			chk_cs0_static: assert property (@(posedge MCLK) disable iff (RST)
				EXT_CS_INDEX[m*3 +: 3] == CS_ZERO |-> !CS_TO_SDRAM[m])
				else $error("chip select zero sent to sdram");
			chk_fixed_ram1: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && addr[BANK_LSB +: BANK_W] == BANK_INTERNAL
				&& addr[AREA_LSB +: AREA_W] == AREA_RAM1 |-> SLAVE_SEL[m*4 +: 4] == SLV_RAM1)
				else $error("second ram moved");

			// Same map checks in every decoder, so no master drifts from the others
			chk_ext_window: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && in_ext
				|-> SLAVE_SEL[m*SEL_W +: SEL_W] == SLV_EXT && EXT_CS_INDEX[m*CS_W +: CS_W] == bank[CS_W-1:0])
				else $error("external bank not on its own chip select");
			chk_internal_only: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && bank == BANK_INTERNAL && area != AREA_BOOT
				|-> SLAVE_SEL[m*SEL_W +: SEL_W] != SLV_EXT && SLAVE_SEL[m*SEL_W +: SEL_W] != SLV_PERIPH)
				else $error("bank zero left the internal memories");
			chk_bank0_cs0: assert property (@(posedge MCLK) disable iff (RST)
				bank == BANK_INTERNAL |-> EXT_CS_INDEX[m*CS_W +: CS_W] == CS_ZERO)
				else $error("bank zero not on chip select zero");
			chk_fixed_rom: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && bank == BANK_INTERNAL && area == AREA_ROM |-> SLAVE_SEL[m*SEL_W +: SEL_W] == SLV_ROM)
				else $error("rom moved");
			chk_fixed_ram0: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && bank == BANK_INTERNAL && area == AREA_RAM0 |-> SLAVE_SEL[m*SEL_W +: SEL_W] == SLV_RAM0)
				else $error("first ram moved");
			chk_usb_cpu_only: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && bank == BANK_INTERNAL && area == AREA_USBH |-> DECODE_ABORT[m] == !IS_CPU)
				else $error("usb host area open to a non processor master");
			chk_idle_quiet: assert property (@(posedge MCLK) disable iff (RST)
				!HSEL_VALID[m] |-> SLAVE_SEL[m*SEL_W +: SEL_W] == SLV_NONE && !DECODE_ABORT[m])
				else $error("idle master selected a slave");
			chk_sdram_cs1: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && bank == BANK_EXT_FIRST && CS1_SDRAM_ASSIGN |-> CS_TO_SDRAM[m])
				else $error("chip select one not sent to sdram");
			chk_remap_every: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && at_boot && remap_q |-> SLAVE_SEL[m*SEL_W +: SEL_W] == SLV_RAM0)
				else $error("remap not seen by every master");
			chk_rom_every: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && at_boot && !remap_q && boot_rom_q |-> SLAVE_SEL[m*SEL_W +: SEL_W] == SLV_ROM)
				else $error("rom boot not seen by every master");
			chk_extboot_every: assert property (@(posedge MCLK) disable iff (RST)
				HSEL_VALID[m] && at_boot && ext_boot |-> EXT_CS_INDEX[m*CS_W +: CS_W] == CS_ZERO)
				else $error("external boot not on chip select zero");

			if (m < CPU_MASTERS)
			begin : g_cpu
				chk_zero_three: assert property (@(posedge MCLK) disable iff (RST)
					HSEL_VALID[m] && at_boot
					|-> SLAVE_SEL[m*SEL_W +: SEL_W] inside {SLV_ROM, SLV_EXT, SLV_RAM0})
					else $error("processor boot area not on a boot slave");
			end
		end
	endgenerate

	// ------------------------------------------------------------
	// Checks on the processor boot view
	// ------------------------------------------------------------
	wire [ADDR_W-1:0] cpu_addr = HADDR[ADDR_W-1:0];
	wire cpu_at_zero = HSEL_VALID[0] && cpu_addr[BANK_LSB +: BANK_W] == BANK_INTERNAL
		&& cpu_addr[AREA_LSB +: AREA_W] == AREA_BOOT;

	chk_remap_ram0: assert property (@(posedge MCLK) disable iff (RST)
		cpu_at_zero && remap_q |-> SLAVE_SEL[3:0] == SLV_RAM0)
		else $error("remap did not place first ram at zero");
	chk_boot_rom: assert property (@(posedge MCLK) disable iff (RST)
		cpu_at_zero && !remap_q && boot_rom_q |-> SLAVE_SEL[3:0] == SLV_ROM)
		else $error("rom boot not at zero");
	chk_boot_ext: assert property (@(posedge MCLK) disable iff (RST)
		cpu_at_zero && ext_boot |-> SLAVE_SEL[3:0] == SLV_EXT && EXT_CS_INDEX[2:0] == CS_ZERO)
		else $error("external boot not at zero");
	chk_pin_held: assert property (@(posedge MCLK) disable iff (RST)
		boot_taken_q && $past(boot_taken_q) |-> $stable(boot_rom_q))
		else $error("boot selection changed after capture");
	chk_remap_sw: assert property (@(posedge MCLK) disable iff (RST)
		$rose(remap_q) |-> $past(REMAP_SET))
		else $error("remap rose without software");
	chk_remap_set: assert property (@(posedge MCLK) disable iff (RST)
		!$past(RST) && $past(REMAP_SET) |-> remap_q)
		else $error("remap request not taken");
	chk_remap_clear: assert property (@(posedge MCLK) disable iff (RST)
		!$past(RST) && $past(REMAP_CLEAR) && !$past(REMAP_SET) |-> !remap_q)
		else $error("remap clear not taken");
	chk_smc_boot: assert property (@(posedge MCLK) disable iff (RST)
		ext_boot |-> SMC_BYTE_SELECT_MODE && SMC_BUS_WIDTH == SMC_WIDTH_16 && SMC_RW_CS_CONTROLLED)
		else $error("static controller not in boot mode");

	// Edge count since release, kept only to pin down the capture point
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			since_rel_q <= 2'h0;
		else if (since_rel_q != CAPTURE_EDGE)
			since_rel_q <= since_rel_q + 2'h1;
	end

	chk_capture_edge: assert property (@(posedge MCLK) disable iff (RST)
		boot_taken_q == (since_rel_q == CAPTURE_EDGE))
		else $error("boot pin captured at the wrong edge");
endmodule
`default_nettype wire

// [matrix_address_decode_boot_remap_tb_top.sv]
`default_nettype none
module matrix_address_decode_boot_remap_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import matrix_decode_pkg::*;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic pin = 1'b1;
	logic boot_done = 1'b0;
	logic want_remap = 1'b0;
	logic cs1_sd = 1'b0;
	logic valid = 1'b1;
	logic [31:0] addr = 32'h0;
	logic rset, rclr, remap_q, rom_q, bs, rw;
	logic [1:0] w;
	logic [23:0] sel;
	logic [17:0] csx;
	logic [5:0] ab, sd;
	int n_errors = 0;
	int n_tests = 0;
	always #2.5 mclk = ~mclk;
	remap_sw_model sw (.MCLK(mclk), .RST(rst), .boot_done(boot_done), .want_remap(want_remap),
		.REMAP_SET(rset), .REMAP_CLEAR(rclr));
	matrix_address_decode_boot_remap dut (.MCLK(mclk), .RST(rst), .BOOT_SOURCE_SELECT_PIN(pin),
		.REMAP_SET(rset), .REMAP_CLEAR(rclr), .CS1_SDRAM_ASSIGN(cs1_sd), .HADDR({6{addr}}),
		.HSEL_VALID({6{valid}}), .SLAVE_SEL(sel), .DECODE_ABORT(ab), .EXT_CS_INDEX(csx),
		.CS_TO_SDRAM(sd), .REMAP_STATE(remap_q), .BOOT_FROM_ROM(rom_q),
		.SMC_BYTE_SELECT_MODE(bs), .SMC_BUS_WIDTH(w), .SMC_RW_CS_CONTROLLED(rw));
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Slave code of masters 0, 1 and 5, abort of master 0, chip select of master 0 for external slaves
	task automatic look(input logic [31:0] a, input logic [3:0] s, input logic [2:0] c, input logic b);
		@(negedge mclk);
		addr = a;
		#1;
		check("slave", sel[3:0], s);
		check("slave m1", sel[7:4], s);
		check("slave m5", sel[23:20], (s == SLV_USBH) ? SLV_NONE : s);
		check("abort", ab[0], b);
		if (s == SLV_EXT)
			check("cs", csx[2:0], c);
	endtask
	task automatic do_reset(input logic p);
		@(negedge mclk);
		rst = 1'b1;
		pin = p;
		boot_done = 1'b0;
		want_remap = 1'b0;
		repeat (3) @(negedge mclk);
		rst = 1'b0;
		repeat (4) @(negedge mclk);
		check("remap", remap_q, 1'b0);
	endtask
	task automatic set_remap(input logic r);
		boot_done = 1'b1;
		want_remap = r;
		repeat (3) @(negedge mclk);
		check("remap", remap_q, r);
	endtask
	task automatic t_boot_rom;
		do_reset(1'b1);
		check("rom", rom_q, 1'b1);
		look(32'h0, SLV_ROM, 3'h0, 1'b0);
		set_remap(1'b1);
		look(32'h0000_0100, SLV_RAM0, 3'h0, 1'b0);
		look(32'h0300_0000, SLV_RAM1, 3'h0, 1'b0);
		set_remap(1'b0);
		look(32'h000f_fffc, SLV_ROM, 3'h0, 1'b0);
		$display("boot rom done");
	endtask
	task automatic t_map;
		logic [3:0] b;
		for (int i = 1; i < 16; i++)
		begin
			b = 4'(i);
			if (i <= 7)
				look({b, 28'h0ab_cdef}, SLV_EXT, b[2:0], 1'b0);
			else if (i == 15)
				look({b, 28'h0ab_cdef}, SLV_PERIPH, 3'h0, 1'b0);
			else
				look({b, 28'h0ab_cdef}, SLV_NONE, 3'h0, 1'b1);
		end
		look(32'h0200_0000, SLV_RAM0, 3'h0, 1'b0);
		look(32'h0040_0000, SLV_NONE, 3'h0, 1'b1);
		look(32'h0500_0000, SLV_USBH, 3'h0, 1'b0);
		check("usb m2", ab[2], 1'b1);
		cs1_sd = 1'b1;
		look(32'h1000_0000, SLV_EXT, 3'h1, 1'b0);
		check("sdram", sd, 6'h3f);
		look(32'h0000_0000, SLV_ROM, 3'h0, 1'b0);
		check("sdram", sd, 6'h00);
		cs1_sd = 1'b0;
		valid = 1'b0;
		look(32'h8000_0000, SLV_NONE, 3'h0, 1'b0);
		valid = 1'b1;
		$display("map done");
	endtask
	task automatic t_boot_ext;
		do_reset(1'b0);
		check("rom", rom_q, 1'b0);
		look(32'h0, SLV_EXT, 3'h0, 1'b0);
		check("smc", {bs, w, rw}, {1'b1, 2'h1, 1'b1});
		@(negedge mclk);
		pin = 1'b1;
		repeat (4) @(negedge mclk);
		check("rom held", rom_q, 1'b0);
		set_remap(1'b1);
		look(32'h0, SLV_RAM0, 3'h0, 1'b0);
		$display("boot ext done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#20000;
		n_errors++;
		tally_and_finish();
	end
	initial
	begin
		t_boot_rom();
		t_map();
		t_boot_ext();
		tally_and_finish();
	end
endmodule
`default_nettype wire

// [matrix_decode_pkg.sv]
`default_nettype none
package matrix_decode_pkg;
	// ------------------------------------------------------------
	// Address map
	// ------------------------------------------------------------
	localparam int ADDR_W = 32;
	localparam int BANK_W = 4;
	localparam int BANK_LSB = 28;
	localparam int NUM_MASTERS = 6;
	localparam int NUM_CS = 8;
	localparam logic [3:0] BANK_INTERNAL = 4'h0;
	localparam logic [3:0] BANK_EXT_FIRST = 4'h1;
	localparam logic [3:0] BANK_EXT_LAST = 4'h7;
	localparam logic [3:0] BANK_PERIPH = 4'hf;
	// Second level inside bank zero, 1 MB areas
	localparam int AREA_LSB = 20;
	localparam int AREA_W = 8;
	localparam logic [7:0] AREA_BOOT = 8'h00;
	localparam logic [7:0] AREA_ROM = 8'h10;
	localparam logic [7:0] AREA_RAM0 = 8'h20;
	localparam logic [7:0] AREA_RAM1 = 8'h30;
	localparam logic [7:0] AREA_USBH = 8'h50;
	// ------------------------------------------------------------
	// Slave selection
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		SLV_NONE = 4'h0,
		SLV_RAM0 = 4'h1,
		SLV_RAM1 = 4'h2,
		SLV_ROM = 4'h3,
		SLV_USBH = 4'h4,
		SLV_EXT = 4'h5,
		SLV_PERIPH = 4'h6
	} slave_t;
	localparam logic [2:0] CS_ZERO = 3'h0;
	localparam logic [2:0] CS_ONE = 3'h1;
	// Static memory controller defaults when booting from chip select zero
	localparam logic [1:0] SMC_WIDTH_16 = 2'h1;
	localparam logic SMC_BYTE_SELECT = 1'b1;
	localparam logic SMC_RW_BY_CS = 1'b1;
endpackage
`default_nettype wire

// [remap_sw_model.sv]
`default_nettype none
// --------------------------------
// Software side of the remap control
// --------------------------------
module remap_sw_model
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic boot_done,
	input wire logic want_remap,
	output logic REMAP_SET,
	output logic REMAP_CLEAR
);
	timeunit 1ns;
	timeprecision 1ps;
	// Requests move off the sampling edge, gated until boot is over
	always_ff @(negedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			REMAP_SET <= 1'b0;
			REMAP_CLEAR <= 1'b0;
		end
		else
		begin
			REMAP_SET <= boot_done & want_remap;
			REMAP_CLEAR <= boot_done & ~want_remap;
		end
	end
endmodule
`default_nettype wire
